// ---- logic/pec_pkg.sv ----
// Package: register map, field layout, reset values and timing of the counter and PCS bank
package pec_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [5:0] IDX_FALSE_CARRIER = 6'h14;
	localparam logic [5:0] IDX_RX_SYM_ERR    = 6'h15;
	localparam logic [5:0] IDX_PCS_CONFIG    = 6'h16;
	localparam logic [5:0] IDX_IRQ_STATUS    = 6'h1A;
	localparam logic [5:0] IDX_IRQ_ENABLE    = 6'h1B;
	localparam logic [5:0] IDX_IRQ_CLEAR     = 6'h1C;

	// ****************************************************************
	// Bus, counter and interrupt widths
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 8;
	localparam int IRQ_W  = 3;

	// ****************************************************************
	// Field positions of the PCS configuration register
	// ****************************************************************
	localparam int PCS_TRUE_QUIET    = 10;
	localparam int PCS_FORCE_SD      = 9;
	localparam int PCS_SD_ALGO       = 8;
	localparam int PCS_DESC_TIMEOUT  = 7;
	localparam int PCS_FORCE_100_OK  = 5;
	localparam int PCS_NRZI_BYPASS   = 2;
	localparam logic [15:0] PCS_WR_MASK  = 16'h07A4;
	localparam logic [15:0] PCS_RST      = 16'h0100;

	// ****************************************************************
	// Interrupt status bit positions
	// ****************************************************************
	localparam int IRQ_FALSE_CARRIER = 0;
	localparam int IRQ_RX_SYM_ERR    = 1;
	localparam int IRQ_DESC_TIMEOUT  = 2;

	// ****************************************************************
	// Reset values and counter limits
	// ****************************************************************
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	// ****************************************************************
	// Descrambler timeout figures and their cycle counts at 25 MHz
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 40;
	localparam int DESC_LONG_MS   = 2;
	localparam int DESC_SHORT_US  = 722;
	localparam int DESC_LONG_CYC  = (DESC_LONG_MS * 1000000) / CLK_PERIOD_NS;
	localparam int DESC_SHORT_CYC = (DESC_SHORT_US * 1000) / CLK_PERIOD_NS;
	localparam int TMR_W          = 16;

endpackage

// ---- logic/pec_counters_pcs.sv ----
// Module: false-carrier and symbol-error counters, PCS configuration, APB slave, interrupt
`timescale 1ns/1ns

// Contract
// - Each false carrier event adds one to the 8-bit false carrier count.
// - The false carrier count stops at FFh and never wraps.
// - Reading either counter clears it to zero; both reset to zero and are read-only.
// - The symbol error count adds one for a carrier event that held an invalid symbol.
// - The symbol error count advances at most once per carrier event.
// - A carrier event that saw a collision never advances the symbol error count.
// - The symbol error count stops at all ones until it is cleared.
// - Reserved upper bits of the counter and PCS registers ignore writes and read zero.
// - PCS bit 10 selects true quiet transmit, reset value zero.
// - PCS bit 9 forces signal detect in the medium attachment.
// - PCS bit 8 selects the enhanced signal detect algorithm and resets to one.
// - PCS bit 7 selects a 2 ms descrambler timeout, otherwise 722 us.
// - PCS bit 5 forces a good 100 Mb/s link indication.
// - PCS bit 2 bypasses NRZI coding in the 100 Mb/s path.
// - Reading the false carrier count also clears the latched false carrier flag.
module pec_counters_pcs #(
	parameter int DESC_LONG_CYCLES  = pec_pkg::DESC_LONG_CYC,
	parameter int DESC_SHORT_CYCLES = pec_pkg::DESC_SHORT_CYC
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [pec_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [pec_pkg::DATA_W-1:0]  pwdata,
	output logic      [pec_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        false_carrier_evt,
	input  wire logic                        rx_carrier_valid,
	input  wire logic                        rx_invalid_symbol,
	input  wire logic                        rx_collision,
	input  wire logic                        rx_idle_seen,
	output logic                             false_carrier_latch,
	output logic                             true_quiet_enable,
	output logic                             force_signal_detect,
	output logic                             signal_detect_algorithm_select,
	output logic                             descrambler_timeout_select,
	output logic                             force_100_link_good,
	output logic                             nrzi_bypass,
	output logic                             descrambler_timeout,
	output logic                             irq
);
	import pec_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [CNT_W-1:0]  fc_cnt_ff;
	logic [CNT_W-1:0]  nxt_fc_cnt;
	logic [CNT_W-1:0]  se_cnt_ff;
	logic [CNT_W-1:0]  nxt_se_cnt;
	logic [15:0]       pcs_cfg_ff;
	logic [IRQ_W-1:0]  irq_stat_ff;
	logic [IRQ_W-1:0]  irq_en_ff;
	logic              irq_ff;
	logic              fc_latch_ff;
	logic              carrier_prev_ff;
	logic              err_seen_ff;
	logic              col_seen_ff;
	logic [TMR_W-1:0]  desc_tmr_ff;
	logic              desc_to_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic [DATA_W-1:0] nxt_prdata;
	logic              pready_ff;
	logic              pslverr_ff;
	logic              nxt_pslverr;
	logic [5:0]        reg_idx;
	logic              apb_setup;
	logic              apb_wr;
	logic              rd_fc;
	logic              rd_se;
	logic              se_evt;
	logic              desc_expire;
	logic [TMR_W-1:0]  desc_limit;
	logic [IRQ_W-1:0]  irq_set;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// Reads are taken in the setup cycle, writes at the completing edge
	assign reg_idx   = paddr[ADDR_W-1:2];
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready_ff & pwrite;
	assign rd_fc     = apb_setup & ~pwrite & (reg_idx == IDX_FALSE_CARRIER);
	assign rd_se     = apb_setup & ~pwrite & (reg_idx == IDX_RX_SYM_ERR);

	// Read data and error for the access phase
	always_comb begin
		nxt_prdata  = '0;
		nxt_pslverr = 1'b0;
		case (reg_idx)
			IDX_FALSE_CARRIER: nxt_prdata[CNT_W-1:0] = fc_cnt_ff;
			IDX_RX_SYM_ERR:    nxt_prdata[CNT_W-1:0] = se_cnt_ff;
			IDX_PCS_CONFIG:    nxt_prdata[15:0]      = pcs_cfg_ff;
			IDX_IRQ_STATUS:    nxt_prdata[IRQ_W-1:0] = irq_stat_ff;
			IDX_IRQ_ENABLE:    nxt_prdata[IRQ_W-1:0] = irq_en_ff;
			IDX_IRQ_CLEAR:     nxt_prdata            = '0;
			default:           nxt_pslverr           = 1'b1;
		endcase
	end

	// Response registers, one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else if (apb_setup) begin
			prdata_ff  <= pwrite ? '0 : nxt_prdata;
			pready_ff  <= 1'b1;
			pslverr_ff <= nxt_pslverr;
		end else begin
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// False carrier counter
	// ****************************************************************
	// clear first, then count
	always_comb begin
		nxt_fc_cnt = rd_fc ? CNT_RST : fc_cnt_ff;
		if (false_carrier_evt && (nxt_fc_cnt != CNT_MAX)) begin
			nxt_fc_cnt = nxt_fc_cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fc_cnt_ff <= CNT_RST;
		end else begin
			fc_cnt_ff <= nxt_fc_cnt;
		end
	end

	// Latched false carrier flag, an event beats the clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fc_latch_ff <= 1'b0;
		end else if (false_carrier_evt) begin
			fc_latch_ff <= 1'b1;
		end else if (rd_fc) begin
			fc_latch_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Symbol error counter
	// ****************************************************************
	// Track what each carrier event saw, judged when carrier drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carrier_prev_ff <= 1'b0;
			err_seen_ff     <= 1'b0;
			col_seen_ff     <= 1'b0;
		end else begin
			carrier_prev_ff <= rx_carrier_valid;
			if (!rx_carrier_valid) begin
				err_seen_ff <= 1'b0;
				col_seen_ff <= 1'b0;
			end else begin
				err_seen_ff <= err_seen_ff | rx_invalid_symbol;
				col_seen_ff <= col_seen_ff | rx_collision;
			end
		end
	end

	assign se_evt = carrier_prev_ff & ~rx_carrier_valid & err_seen_ff & ~col_seen_ff;

	always_comb begin
		nxt_se_cnt = rd_se ? CNT_RST : se_cnt_ff;
		if (se_evt && (nxt_se_cnt != CNT_MAX)) begin
			nxt_se_cnt = nxt_se_cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			se_cnt_ff <= CNT_RST;
		end else begin
			se_cnt_ff <= nxt_se_cnt;
		end
	end

	// ****************************************************************
	// PCS configuration
	// ****************************************************************
	// only defined bits are writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcs_cfg_ff <= PCS_RST;
		end else if (apb_wr && (reg_idx == IDX_PCS_CONFIG)) begin
			pcs_cfg_ff <= pwdata[15:0] & PCS_WR_MASK;
		end
	end

	assign true_quiet_enable              = pcs_cfg_ff[PCS_TRUE_QUIET];
	assign force_signal_detect            = pcs_cfg_ff[PCS_FORCE_SD];
	assign signal_detect_algorithm_select = pcs_cfg_ff[PCS_SD_ALGO];
	assign descrambler_timeout_select     = pcs_cfg_ff[PCS_DESC_TIMEOUT];
	assign force_100_link_good            = pcs_cfg_ff[PCS_FORCE_100_OK];
	assign nrzi_bypass                    = pcs_cfg_ff[PCS_NRZI_BYPASS];

	// ****************************************************************
	// Descrambler timeout timer
	// ****************************************************************
	// 2 ms or 722 us limit
	assign desc_limit  = pcs_cfg_ff[PCS_DESC_TIMEOUT] ? TMR_W'(DESC_LONG_CYCLES - 1)
	                                                  : TMR_W'(DESC_SHORT_CYCLES - 1);
	assign desc_expire = ~rx_idle_seen & ~desc_to_ff & (desc_tmr_ff >= desc_limit);

	// Idle symbols restart the timer, expiry holds until the next idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_tmr_ff <= '0;
			desc_to_ff  <= 1'b0;
		end else if (rx_idle_seen) begin
			desc_tmr_ff <= '0;
			desc_to_ff  <= 1'b0;
		end else if (desc_expire) begin
			desc_to_ff  <= 1'b1;
		end else if (!desc_to_ff) begin
			desc_tmr_ff <= desc_tmr_ff + 16'h0001;
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	assign irq_set = {desc_expire, se_evt, false_carrier_evt};

	// Sticky status, set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= IRQ_RST;
		end else if (apb_wr && (reg_idx == IDX_IRQ_CLEAR)) begin
			irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	// Enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_ff <= IRQ_RST;
		end else if (apb_wr && (reg_idx == IDX_IRQ_ENABLE)) begin
			irq_en_ff <= pwdata[IRQ_W-1:0];
		end
	end

	// Level interrupt, one cycle behind status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata              = prdata_ff;
	assign pready              = pready_ff;
	assign pslverr             = pslverr_ff;
	assign false_carrier_latch = fc_latch_ff;
	assign descrambler_timeout = desc_to_ff;
	assign irq                 = irq_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_fc_count_up: assert property (@(posedge pclk) disable iff (!presetn)
		false_carrier_evt && !rd_fc && (fc_cnt_ff != 8'hFF)
		|=> fc_cnt_ff == $past(fc_cnt_ff) + 8'h01)
		else $error("false carrier count did not advance");

	a_fc_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		(fc_cnt_ff == 8'hFF) && !rd_fc |=> fc_cnt_ff == 8'hFF)
		else $error("false carrier count left its maximum");

	a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
		rd_se && !se_evt ##1 pready_ff |-> se_cnt_ff == 8'h00 && !pslverr_ff)
		else $error("symbol error count not cleared by read");

	a_se_count_up: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(rx_carrier_valid) && err_seen_ff && !col_seen_ff && !rd_se
		&& (se_cnt_ff != 8'hFF) |=> se_cnt_ff == $past(se_cnt_ff) + 8'h01)
		else $error("symbol error count did not advance");

	a_se_once: assert property (@(posedge pclk) disable iff (!presetn)
		rx_carrier_valid && !rd_se |=> se_cnt_ff == $past(se_cnt_ff))
		else $error("symbol error count moved inside a carrier event");

	a_se_collision: assert property (@(posedge pclk) disable iff (!presetn)
		rx_carrier_valid && rx_collision && !rd_se ##1 !rx_carrier_valid && !rd_se
		|=> se_cnt_ff == $past(se_cnt_ff, 2))
		else $error("symbol error counted despite collision");

	a_se_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		(se_cnt_ff == 8'hFF) && !rd_se |=> se_cnt_ff == 8'hFF)
		else $error("symbol error count left its maximum");

	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready_ff |-> prdata_ff[31:16] == 16'h0000
		&& (pcs_cfg_ff & ~16'h07A4) == 16'h0000)
		else $error("reserved bits not zero");

	a_desc_limit: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(desc_to_ff) |-> $past(desc_tmr_ff) == $past(desc_limit))
		else $error("descrambler timeout at wrong count");

	a_latch_clear: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fc && !false_carrier_evt |=> !fc_latch_ff && pready_ff)
		else $error("false carrier latch not cleared by read");

	a_clear_count: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fc && false_carrier_evt |=> fc_cnt_ff == 8'h01)
		else $error("event lost at clearing read");

	a_fc_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
		rd_fc && !false_carrier_evt |=> fc_cnt_ff == 8'h00)
		else $error("false carrier count not cleared by read");

	a_se_clear_count: assert property (@(posedge pclk) disable iff (!presetn)
		rd_se && se_evt |=> se_cnt_ff == 8'h01)
		else $error("symbol error lost at clearing read");

	a_se_no_count: assert property (@(posedge pclk) disable iff (!presetn)
		!(carrier_prev_ff && !rx_carrier_valid) && !rd_se |=> se_cnt_ff == $past(se_cnt_ff))
		else $error("symbol error count moved outside a carrier end");

	a_latch_set: assert property (@(posedge pclk) disable iff (!presetn)
		false_carrier_evt |=> fc_latch_ff)
		else $error("false carrier latch not set by event");

	a_pcs_write: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr && (reg_idx == IDX_PCS_CONFIG)
		|=> {16'h0000, pcs_cfg_ff} == ($past(pwdata) & {16'h0000, PCS_WR_MASK}))
		else $error("pcs config write stored wrong bits");

	a_timeout_hold: assert property (@(posedge pclk) disable iff (!presetn)
		desc_to_ff && !rx_idle_seen |=> desc_to_ff)
		else $error("descrambler timeout dropped without idle");

endmodule

// ---- sim/pec_counters_pcs_tb.sv ----
// Testbench: APB, counter, PCS configuration, timer and interrupt checks
`timescale 1ns/1ns
module pec_counters_pcs_tb;
	import pec_pkg::*;
	localparam int SHORT_C = 8;
	localparam int LONG_C  = 20;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic              fc_evt, cv, inv, coll, idle, err;
	logic              fc_latch, tq, fsd, sda, dts, f100, nrzi, dto, irq;
	logic [31:0]       seed, wd;
	logic [7:0]        exp_cnt;
	int                n_errors, check_count, n;

	// ****************************************************************
	// Design under test with short descrambler timeouts
	// ****************************************************************
	pec_counters_pcs #(.DESC_LONG_CYCLES(LONG_C), .DESC_SHORT_CYCLES(SHORT_C))
	pec_counters_pcs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .false_carrier_evt(fc_evt), .rx_carrier_valid(cv),
		.rx_invalid_symbol(inv), .rx_collision(coll), .rx_idle_seen(idle),
		.false_carrier_latch(fc_latch), .true_quiet_enable(tq), .force_signal_detect(fsd),
		.signal_detect_algorithm_select(sda), .descrambler_timeout_select(dts),
		.force_100_link_good(f100), .nrzi_bypass(nrzi), .descrambler_timeout(dto), .irq(irq));

	// Clock at 25 MHz
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [7:0] sat_inc(input logic [7:0] c);
		return (c == CNT_MAX) ? c : c + 8'h01;
	endfunction

	function automatic logic [31:0] pcs_pins(input logic [31:0] v);
		return {26'h0, v[10], v[9], v[8], v[7], v[5], v[2]};
	endfunction

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask

	// One APB transfer; optional false carrier pulse in the setup cycle
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
			input logic fc_at_setup);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		fc_evt  <= fc_at_setup;
		@(posedge pclk);
		penable <= 1'b1;
		fc_evt  <= 1'b0;
		// Values read right after the edge are those sampled at it
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic fc_pulses(input int k);
		repeat (k) begin
			@(posedge pclk);
			fc_evt <= 1'b1;
			@(posedge pclk);
			fc_evt <= 1'b0;
		end
	endtask

	// One carrier event with some invalid symbols and an optional collision
	task automatic carrier(input int n_inv, input logic c);
		@(posedge pclk);
		cv   <= 1'b1;
		coll <= c;
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			inv <= (i < n_inv);
		end
		@(posedge pclk);
		inv  <= 1'b0;
		cv   <= 1'b0;
		coll <= 1'b0;
		@(posedge pclk);
	endtask

	// Restart the timer and count cycles until the timeout shows
	task automatic timer_run(input int lim);
		@(posedge pclk);
		idle <= 1'b1;
		@(posedge pclk);
		idle <= 1'b0;
		@(negedge pclk);
		chk_pin(dto, 1'b0, "timeout after idle");
		n = 1;
		while (dto !== 1'b1 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		// Idle edge plus limit cycles, seen at the following falling edge
		chk_pin(n == lim + 1, 1'b1, "timeout span");
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (30000) @(posedge pclk);
		n_errors++;
		close_out();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{psel, penable, pwrite, fc_evt, cv, inv, coll, idle} = '0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		seed = 32'h0000_4de8;
		n_errors = 0;
		check_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk_reg(pcs_pins({21'h0, tq, fsd, sda, dts, 1'b0, f100, 2'b0, nrzi, 2'b0}),
			pcs_pins({16'h0, PCS_RST}), "pcs pins at reset");
		apb(1'b0, IDX_PCS_CONFIG, '0, 1'b0);
		chk_reg(rd, 32'h0000_0100, "pcs reset");
		apb(1'b0, IDX_FALSE_CARRIER, '0, 1'b0);
		chk_reg(rd, 32'h0000_0000, "fc reset");
		apb(1'b0, IDX_RX_SYM_ERR, '0, 1'b0);
		chk_reg(rd, 32'h0000_0000, "se reset");
		// Random false carrier count, latch, clear on read
		n = int'(xs() % 20) + 1;
		fc_pulses(n);
		@(negedge pclk);
		chk_pin(fc_latch, 1'b1, "latch set");
		apb(1'b1, IDX_FALSE_CARRIER, 32'hFFFF_FFFF, 1'b0);
		apb(1'b0, IDX_FALSE_CARRIER, '0, 1'b0);
		chk_reg(rd, 32'(n), "fc count");
		chk_pin(fc_latch, 1'b0, "latch cleared");
		apb(1'b0, IDX_FALSE_CARRIER, '0, 1'b0);
		chk_reg(rd, 32'h0000_0000, "fc cleared");
		// Event meeting the clearing read
		fc_pulses(2);
		apb(1'b0, IDX_FALSE_CARRIER, '0, 1'b1);
		chk_reg(rd, 32'h0000_0002, "fc before clash");
		apb(1'b0, IDX_FALSE_CARRIER, '0, 1'b0);
		chk_reg(rd, 32'h0000_0001, "fc after clash");
		fc_pulses(260);
		apb(1'b0, IDX_FALSE_CARRIER, '0, 1'b0);
		chk_reg(rd, 32'h0000_00FF, "fc saturates");
		// Random carrier events, then saturation
		exp_cnt = CNT_RST;
		repeat (40) begin
			wd = xs();
			carrier(int'(wd[1:0]), wd[3:2] == 2'b00);
			if (wd[1:0] != 2'b00 && wd[3:2] != 2'b00)
				exp_cnt = sat_inc(exp_cnt);
		end
		apb(1'b0, IDX_RX_SYM_ERR, '0, 1'b0);
		chk_reg(rd, {24'h0, exp_cnt}, "se count");
		repeat (258) carrier(1, 1'b0);
		apb(1'b0, IDX_RX_SYM_ERR, '0, 1'b0);
		chk_reg(rd, 32'h0000_00FF, "se saturates");
		apb(1'b0, IDX_RX_SYM_ERR, '0, 1'b0);
		chk_reg(rd, 32'h0000_0000, "se cleared");
		// PCS configuration: corner value then random values
		for (int i = 0; i < 9; i++) begin
			wd = (i == 0) ? 32'hFFFF_E7A4 : xs() & ~32'h0000_185B;
			apb(1'b1, IDX_PCS_CONFIG, wd, 1'b0);
			apb(1'b0, IDX_PCS_CONFIG, '0, 1'b0);
			chk_reg(rd, {16'h0, wd[15:0] & PCS_WR_MASK}, "pcs readback");
			chk_reg({26'h0, tq, fsd, sda, dts, f100, nrzi}, pcs_pins(wd),
				"pcs pins");
		end
		apb(1'b0, 6'h20, '0, 1'b0);
		chk_pin(err, 1'b1, "unmapped error");
		chk_reg(rd, 32'h0000_0000, "unmapped data");
		// Interrupt: masked, enabled, cleared
		apb(1'b1, IDX_IRQ_ENABLE, '0, 1'b0);
		apb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0007, 1'b0);
		fc_pulses(1);
		repeat (3) @(negedge pclk);
		chk_pin(irq, 1'b0, "irq masked");
		apb(1'b0, IDX_IRQ_STATUS, '0, 1'b0);
		chk_pin(rd[IRQ_FALSE_CARRIER], 1'b1, "status set");
		apb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0001, 1'b0);
		repeat (2) @(negedge pclk);
		chk_pin(irq, 1'b1, "irq raised");
		apb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0001, 1'b0);
		repeat (2) @(negedge pclk);
		chk_pin(irq, 1'b0, "irq cleared");
		apb(1'b0, IDX_IRQ_STATUS, '0, 1'b0);
		chk_pin(rd[IRQ_FALSE_CARRIER], 1'b0, "status cleared");
		// Descrambler timeout, short then long
		apb(1'b1, IDX_PCS_CONFIG, 32'h0000_0100, 1'b0);
		timer_run(SHORT_C);
		apb(1'b1, IDX_PCS_CONFIG, 32'h0000_0180, 1'b0);
		timer_run(LONG_C);
		close_out();
	end
endmodule
